/* File: design/pbam_top.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Program bank address mapper, top level
// ----------------------------------------------------------------------
module pbam_top #(
    parameter int PC_W   = pbam_pkg::PC_W,
    parameter int BANK_W = pbam_pkg::BANK_W
) (
    input  wire logic              clk_sys_in,
    input  wire logic              srst_in,
    input  wire logic [1:0]        config_sel_in,
    input  wire logic              max_mode_in,
    input  wire logic [BANK_W-1:0] fixed_bank_in,
    input  wire logic              fetch_req_in,
    input  wire logic [PC_W-1:0]   pc_in,
    input  wire logic              nb_wr_acc_in,
    input  wire logic [BANK_W-1:0] acc_in,
    input  wire logic              bank_immediate_load_in,
    input  wire logic [BANK_W-1:0] imm_in,
    input  wire logic              branch_issue_in,
    input  wire logic              branch_resolve_in,
    input  wire logic              branch_taken_in,
    input  wire logic              call_push_in,
    input  wire logic              return_pop_in,
    input  wire logic [BANK_W-1:0] pop_bank_in,
    input  wire logic              pc_copy_req_in,
    output logic [23:0]            phys_addr_out,
    output logic                   fetch_valid_out,
    output logic                   vector_fetch_out,
    output logic [BANK_W-1:0]      code_bank_select_out,
    output logic [BANK_W-1:0]      next_bank_latch_out,
    output logic [BANK_W-1:0]      push_bank_out,
    output logic                   push_valid_out,
    output logic [PC_W-1:0]        pair_index_word_out,
    output logic                   pc_copy_valid_out,
    output logic                   branch_pending_out,
    output logic                   config_ready_out
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // The address former is built for a 16-bit PC and 8-bit banks.
    generate
        if (PC_W != 16) begin : g_bad_pc
            $error("pbam_top: PC_W must be 16");
        end
        if (BANK_W != 8) begin : g_bad_bank
            $error("pbam_top: BANK_W must be 8");
        end
    endgenerate

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {
        ST_RUN,
        ST_WAIT_COND
    } pbam_fsm_type;

    typedef struct packed {
        pbam_fsm_type      fsm;
        logic              cfg_loaded;
        logic              small_cfg;
        logic              max_mode;
        logic [BANK_W-1:0] code_bank;
        logic [BANK_W-1:0] next_bank;
        logic [23:0]       addr;
        logic              fetch_v;
        logic              vec;
        logic [BANK_W-1:0] push_bank;
        logic              push_v;
        logic [PC_W-1:0]   pc_copy;
        logic              pc_copy_v;
    } pbam_state_type;

    pbam_state_type state_ff;
    pbam_state_type nxt_state;

    logic [23:0] form_addr;
    logic        form_vec;

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    // True for both small configurations, which have no banking at all.
    function automatic logic is_small_cfg(input logic [1:0] sel);
        is_small_cfg = (sel == pbam_pkg::CFG_SMALL_ZERO) ||
                       (sel == pbam_pkg::CFG_SMALL_ONE);
    endfunction

    // The bank may move only in a banked configuration in maximum mode.
    function automatic logic bank_movable(input pbam_state_type s);
        bank_movable = s.cfg_loaded && !s.small_cfg && s.max_mode;
    endfunction

    // ------------------------------------------------------------------
    // Address forming
    // ------------------------------------------------------------------
    // The fetch uses the bank in force at the start of the cycle, so a
    // fetch in the same cycle as a taken branch still sees the old bank.
    pbam_addr_form u_addr_form (
        .pc_in          (pc_in),
        .code_bank_in   (state_ff.code_bank),
        .small_cfg_in   (state_ff.small_cfg),
        .phys_addr_out  (form_addr),
        .vector_hit_out (form_vec)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic resolve_now;
        resolve_now = 1'b0;
        nxt_state   = state_ff;

        // One-cycle strobes drop unless renewed below.
        nxt_state.fetch_v   = 1'b0;
        nxt_state.push_v    = 1'b0;
        nxt_state.pc_copy_v = 1'b0;

        // Configuration straps are caught once, on the first edge after
        // reset release; changing them later has no effect by design.
        if (!state_ff.cfg_loaded) begin
            nxt_state.cfg_loaded = 1'b1;
            nxt_state.small_cfg  = is_small_cfg(config_sel_in);
            nxt_state.max_mode   = max_mode_in;
            if (is_small_cfg(config_sel_in)) begin
                nxt_state.code_bank = pbam_pkg::SMALL_BANK;          // R7
                nxt_state.next_bank = pbam_pkg::SMALL_BANK;          // R23
            end else if (!max_mode_in) begin
                nxt_state.code_bank = fixed_bank_in;                 // R7
                nxt_state.next_bank = fixed_bank_in;                 // R23
            end
        end

        // Fetch address goes out one cycle after the request. When the PC
        // wraps past FFFFH it simply lands in the common area again; no
        // path here touches the code bank on a wrap.
        if (fetch_req_in) begin
            nxt_state.addr    = form_addr;                           // R14
            nxt_state.fetch_v = 1'b1;
            nxt_state.vec     = form_vec;                            // R5
        end

        // Copy of the PC for the register pair: the instruction's own
        // address plus two, i.e. the following instruction.
        if (pc_copy_req_in) begin
            nxt_state.pc_copy   = pc_in + PC_W'(pbam_pkg::PC_COPY_INC); // R13
            nxt_state.pc_copy_v = 1'b1;
        end

        // Next-bank loads; the accumulator source wins if both strobe.
        // The code bank itself has no write path from software.
        if (bank_movable(state_ff)) begin
            if (nb_wr_acc_in) begin
                nxt_state.next_bank = acc_in;                        // R18 R17
            end else if (bank_immediate_load_in) begin
                nxt_state.next_bank = imm_in;                        // R18 R17
            end
        end

        // Calls in maximum mode hand the calling bank to the stack logic.
        if (call_push_in && bank_movable(state_ff)) begin
            nxt_state.push_bank = state_ff.code_bank;                // R21
            nxt_state.push_v    = 1'b1;
        end

        // Branch resolution. A resolve is accepted while waiting, or in
        // the same cycle as the issue for branches known at once.
        case (state_ff.fsm)
            ST_RUN: begin
                if (branch_issue_in) begin
                    if (branch_resolve_in) begin
                        resolve_now = 1'b1;
                    end else begin
                        nxt_state.fsm = ST_WAIT_COND;
                    end
                end
            end
            ST_WAIT_COND: begin
                if (branch_resolve_in) begin
                    resolve_now   = 1'b1;
                    nxt_state.fsm = ST_RUN;
                end
            end
            default: begin
                nxt_state.fsm = ST_RUN;
            end
        endcase

        // An untaken resolution overrides a next-bank load in the same cycle, and a taken one copies the old next bank; the
        // load is meant to precede the branch by at least one cycle.
        if (resolve_now && bank_movable(state_ff)) begin
            if (branch_taken_in) begin
                nxt_state.code_bank = state_ff.next_bank;            // R19 R16 R8
            end else begin
                nxt_state.next_bank = state_ff.code_bank;            // R20
            end
        end

        // A return in maximum mode restores the caller's bank. Both bank
        // registers follow, so no stale pending selection survives.
        if (return_pop_in && bank_movable(state_ff)) begin
            nxt_state.code_bank = pop_bank_in;                       // R22 R16
            nxt_state.next_bank = pop_bank_in;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            state_ff.fsm        <= ST_RUN;
            state_ff.cfg_loaded <= 1'b0;
            state_ff.small_cfg  <= 1'b0;
            state_ff.max_mode   <= 1'b0;
            state_ff.code_bank  <= pbam_pkg::RST_CODE_BANK;          // R15
            state_ff.next_bank  <= pbam_pkg::RST_CODE_BANK;          // R23
            state_ff.addr       <= pbam_pkg::RST_ADDR;
            state_ff.fetch_v    <= 1'b0;
            state_ff.vec        <= 1'b0;
            state_ff.push_bank  <= '0;
            state_ff.push_v     <= 1'b0;
            state_ff.pc_copy    <= '0;
            state_ff.pc_copy_v  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from the state register
    // ------------------------------------------------------------------
    assign phys_addr_out        = state_ff.addr;
    assign fetch_valid_out      = state_ff.fetch_v;
    assign vector_fetch_out     = state_ff.vec;
    assign code_bank_select_out = state_ff.code_bank;
    assign next_bank_latch_out  = state_ff.next_bank;
    assign push_bank_out        = state_ff.push_bank;
    assign push_valid_out       = state_ff.push_v;
    assign pair_index_word_out  = state_ff.pc_copy;
    assign pc_copy_valid_out    = state_ff.pc_copy_v;
    assign branch_pending_out   = (state_ff.fsm == ST_WAIT_COND);
    assign config_ready_out     = state_ff.cfg_loaded;

endmodule

/* File: design/pbam_pkg.sv */
// How it works
// R1: Code fetched only from lower 8M half.
// R2: Small configurations limit space to 64K.
// R3: Program memory is 32K banks 0..255.
// R4: Logical lower half always maps bank 0.
// R5: Lowest 256 common addresses hold vectors.
// R6: Logical upper half maps code bank register.
// R7: Small configs fix bank 1; minimum mode fixed.
// R8: Code bank register holds 8-bit bank number.
// R9: PC low 15 bits drive low address lines.
// R10: Bank lines zero or code bank by PC top.
// R11: Data region line is zero on fetches.
// R12: Small configs output raw 16-bit PC.
// R13: PC copy yields instruction address plus two.
// R14: PC overflow leaves code bank unchanged.
// R15: Reset loads code bank with one.
// R16: Code bank changes only on taken branch or return.
// R17: No direct software write to code bank.
// R18: Next bank loads from accumulator or immediate.
// R19: Taken branch copies next bank into code bank.
// R20: Untaken branch copies code bank into next bank.
// R21: Maximum mode calls push code bank value.
// R22: Maximum mode returns pop saved code bank.
// R23: Next bank resets equal to code bank.
package pbam_pkg;

    // ------------------------------------------------------------------
    // Address geometry
    // ------------------------------------------------------------------
    localparam int PC_W        = 16;
    localparam int BANK_W      = 8;
    localparam int PADDR_W     = 24;
    localparam int OFFS_W      = 15;               // 32K bytes per bank.
    localparam int BANK_LSB    = 15;
    localparam int DATA_LINE   = 23;
    localparam int PC_TOP      = 15;
    localparam int VEC_TOP_W   = 16;               // Bits above vector page.
    localparam int PC_COPY_INC = 2;

    // ------------------------------------------------------------------
    // Reset values and fixed banks
    // ------------------------------------------------------------------
    localparam logic [7:0]  RST_CODE_BANK  = 8'h01;
    localparam logic [7:0]  SMALL_BANK     = 8'h01;
    localparam logic [7:0]  COMMON_BANK    = 8'h00;
    localparam logic [23:0] RST_ADDR       = 24'h000000;

    // ------------------------------------------------------------------
    // Configuration encodings on config_sel_in
    // ------------------------------------------------------------------
    localparam logic [1:0] CFG_SMALL_ZERO   = 2'h0;
    localparam logic [1:0] CFG_SMALL_ONE    = 2'h1;
    localparam logic [1:0] CFG_BANKED_TWO   = 2'h2;
    localparam logic [1:0] CFG_BANKED_THREE = 2'h3;

endpackage

/* File: design/pbam_addr_form.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Logical to physical program address former
// ----------------------------------------------------------------------
module pbam_addr_form (
    input  wire logic [15:0] pc_in,
    input  wire logic [7:0]  code_bank_in,
    input  wire logic        small_cfg_in,
    output logic      [23:0] phys_addr_out,
    output logic             vector_hit_out
);

    // Pure combinational mapping; the caller registers the result.
    always_comb begin
        if (small_cfg_in) begin
            // The bus is only 16 bits wide, so the PC goes out untouched.
            phys_addr_out = {8'h00, pc_in};                          // R12 R2
        end else begin
            phys_addr_out[pbam_pkg::OFFS_W-1:0] =
                pc_in[pbam_pkg::OFFS_W-1:0];                         // R9 R3
            phys_addr_out[pbam_pkg::DATA_LINE-1:pbam_pkg::BANK_LSB] =
                pc_in[pbam_pkg::PC_TOP] ? code_bank_in
                                        : pbam_pkg::COMMON_BANK;     // R10 R4 R6
            phys_addr_out[pbam_pkg::DATA_LINE] = 1'b0;               // R11 R1
        end
        // The vector page is the lowest 256 bytes of the common bank.
        vector_hit_out = (phys_addr_out[23:8] == 16'h0000);          // R5
    end

endmodule

/* File: test/pbam_top_chk.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker for the program bank address mapper.
// ----------------------------------------------------------------
module pbam_chk #(
    parameter int PC_W   = 16,
    parameter int BANK_W = 8
) (
    input wire logic              clk_sys_in,
    input wire logic              srst_in,
    input wire logic [1:0]        config_sel_in,
    input wire logic              max_mode_in,
    input wire logic              fetch_req_in,
    input wire logic [PC_W-1:0]   pc_in,
    input wire logic              branch_resolve_in,
    input wire logic              branch_taken_in,
    input wire logic              return_pop_in,
    input wire logic              pc_copy_req_in,
    input wire logic [23:0]       phys_addr_out,
    input wire logic              fetch_valid_out,
    input wire logic              vector_fetch_out,
    input wire logic [BANK_W-1:0] code_bank_select_out,
    input wire logic [BANK_W-1:0] next_bank_latch_out,
    input wire logic [PC_W-1:0]   pair_index_word_out,
    input wire logic              branch_pending_out,
    input wire logic              config_ready_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);

    // A branch resolving while the bank unit is live and unopposed.
    sequence s_resolve(bit tk);
        branch_pending_out && branch_resolve_in && branch_taken_in == tk
        && !return_pop_in && config_sel_in[1] && max_mode_in
        && config_ready_out;
    endsequence

    a_fetch_pulse: assert property (fetch_valid_out == $past(fetch_req_in))
        else $error("fetch valid does not follow request");
    a_low_lines: assert property (fetch_req_in |=>
        phys_addr_out[14:0] == $past(pc_in[14:0]))
        else $error("low address lines wrong");
    a_data_line_zero: assert property (fetch_valid_out |->
        !phys_addr_out[23]) else $error("data region line set");
    a_common_bank: assert property (fetch_req_in && !pc_in[15] |=>
        phys_addr_out[22:15] == 8'h00) else $error("common area not 0");
    a_upper_bank: assert property (fetch_req_in && pc_in[15]
        && config_sel_in[1] |=>
        phys_addr_out[22:15] == $past(code_bank_select_out))
        else $error("upper half bank wrong");
    // The vector page is physical: an upper-half fetch with bank 0 in a
    // banked configuration lands there as well.
    a_vector_flag: assert property (fetch_req_in |=>
        vector_fetch_out == ($past(pc_in[14:8]) == 7'h00
        && (!$past(pc_in[15])
        || $past(config_sel_in[1] && code_bank_select_out == 8'h00))))
        else $error("vector flag wrong");
    a_reset_banks: assert property ($fell(srst_in) |->
        code_bank_select_out == 8'h01 && next_bank_latch_out == 8'h01)
        else $error("reset bank values wrong");
    a_bank_hold: assert property ($changed(code_bank_select_out) |->
        $past(branch_resolve_in || return_pop_in) || $past(srst_in, 2))
        else $error("code bank changed without cause");
    a_taken_copy: assert property (s_resolve(1'b1) |=>
        code_bank_select_out == $past(next_bank_latch_out))
        else $error("taken branch did not load bank");
    a_untaken_copy: assert property (s_resolve(1'b0) |=>
        next_bank_latch_out == $past(code_bank_select_out))
        else $error("untaken branch did not restore");
    a_copy_plus_two: assert property (pc_copy_req_in |=>
        pair_index_word_out == $past(pc_in) + 16'h0002)
        else $error("pc copy value wrong");
endmodule

bind pbam_top pbam_chk #(.PC_W(PC_W), .BANK_W(BANK_W)) u_chk (
    .clk_sys_in, .srst_in, .config_sel_in, .max_mode_in, .fetch_req_in,
    .pc_in, .branch_resolve_in, .branch_taken_in, .return_pop_in,
    .pc_copy_req_in, .phys_addr_out, .fetch_valid_out, .vector_fetch_out,
    .code_bank_select_out, .next_bank_latch_out, .pair_index_word_out,
    .branch_pending_out, .config_ready_out);

/* File: test/pbam_prog_mem.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Program memory on the physical address bus.
// ----------------------------------------------------------------
module pbam_prog_mem (
    input  wire logic        clk_sys_in,
    input  wire logic [23:0] phys_addr_in,
    input  wire logic        fetch_valid_in,
    output logic      [7:0]  rd_data_out
);
    // Data lasts one cycle; otherwise the bus inverts its last value on
    // every idle edge, so the fresh byte shows again every second idle cycle.
    always_ff @(posedge clk_sys_in) begin
        if (fetch_valid_in) begin
            rd_data_out <= phys_addr_in[7:0] ^ phys_addr_in[22:15];
        end else begin
            rd_data_out <= ~rd_data_out;
        end
    end
endmodule

/* File: test/testbench.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Directed bench for the program bank address mapper.
// ----------------------------------------------------------------
module testbench;
    logic        clk_sys_in, srst_in, max_mode_in, fetch_req_in;
    logic        nb_wr_acc_in, bank_immediate_load_in, branch_issue_in;
    logic        branch_resolve_in, branch_taken_in, call_push_in;
    logic        return_pop_in, pc_copy_req_in, fetch_valid_out;
    logic        vector_fetch_out, push_valid_out, pc_copy_valid_out;
    logic        branch_pending_out, config_ready_out;
    logic [1:0]  config_sel_in;
    logic [7:0]  fixed_bank_in, acc_in, imm_in, pop_bank_in, mem_data;
    logic [7:0]  code_bank_select_out, next_bank_latch_out, push_bank_out;
    logic [15:0] pc_in, pair_index_word_out;
    logic [23:0] phys_addr_out;
    int          miscompares, checks_done, cyc;

    pbam_top u_dut (.clk_sys_in, .srst_in, .config_sel_in, .max_mode_in,
        .fixed_bank_in, .fetch_req_in, .pc_in, .nb_wr_acc_in, .acc_in,
        .bank_immediate_load_in, .imm_in, .branch_issue_in,
        .branch_resolve_in, .branch_taken_in, .call_push_in,
        .return_pop_in, .pop_bank_in, .pc_copy_req_in, .phys_addr_out,
        .fetch_valid_out, .vector_fetch_out, .code_bank_select_out,
        .next_bank_latch_out, .push_bank_out, .push_valid_out,
        .pair_index_word_out, .pc_copy_valid_out, .branch_pending_out,
        .config_ready_out);
    pbam_prog_mem u_mem (.clk_sys_in, .phys_addr_in(phys_addr_out),
        .fetch_valid_in(fetch_valid_out), .rd_data_out(mem_data));

    // Clock, and a cycle ceiling well above the directed run length.
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Straps are captured once after reset, so each setup resets.
    task automatic rst(input logic [1:0] c, input logic m,
                       input logic [7:0] b);
        @(posedge clk_sys_in);
        config_sel_in <= c;
        max_mode_in   <= m;
        fixed_bank_in <= b;
        srst_in       <= 1'b1;
        repeat (8) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        #1;
        chk(config_ready_out, 24'h1);
    endtask

    // 0 acc load, 1 immediate load, 2/3 branch taken/not, 4 call,
    // 5 return, 6 pc copy, 7 fetch. Branches resolve one cycle late.
    task automatic op(input int k, input logic [15:0] v);
        @(posedge clk_sys_in);
        pc_in  <= v;
        acc_in <= v[7:0];
        imm_in <= v[7:0];
        pop_bank_in <= v[7:0];
        case (k)
            0: nb_wr_acc_in <= 1'b1;
            1: bank_immediate_load_in <= 1'b1;
            2, 3: branch_issue_in <= 1'b1;
            4: call_push_in <= 1'b1;
            5: return_pop_in <= 1'b1;
            6: pc_copy_req_in <= 1'b1;
            default: fetch_req_in <= 1'b1;
        endcase
        if (k == 2 || k == 3) begin
            @(posedge clk_sys_in);
            branch_issue_in   <= 1'b0;
            branch_resolve_in <= 1'b1;
            branch_taken_in   <= (k == 2);
        end
        @(posedge clk_sys_in);
        {nb_wr_acc_in, bank_immediate_load_in, branch_issue_in,
         branch_resolve_in, call_push_in, return_pop_in, pc_copy_req_in,
         fetch_req_in} <= 8'h00;
        #1;
    endtask

    task automatic f(input logic [15:0] pc, input logic [23:0] exp);
        op(7, pc);
        chk(phys_addr_out, exp);
    endtask

    // Main sequence: banked maximum, banked minimum, small configs.
    initial begin
        {srst_in, max_mode_in, fetch_req_in, nb_wr_acc_in, branch_issue_in,
         bank_immediate_load_in, branch_resolve_in, branch_taken_in,
         call_push_in, return_pop_in, pc_copy_req_in} = 11'h400;
        {config_sel_in, fixed_bank_in, acc_in, imm_in, pop_bank_in} = 34'h0;
        pc_in = 16'h0000;
        rst(2'h3, 1'b1, 8'h00);
        chk(code_bank_select_out, 24'h01);
        chk(next_bank_latch_out, 24'h01);
        f(16'h8123, 24'h008123);
        f(16'h0042, 24'h000042);
        chk(vector_fetch_out, 24'h1);
        f(16'h7FFF, 24'h007FFF);
        chk(vector_fetch_out, 24'h0);
        op(1, 16'h005A);
        chk(next_bank_latch_out, 24'h5A);
        f(16'h8000, 24'h008000);
        op(3, 16'h0000);
        chk(next_bank_latch_out, 24'h01);
        op(0, 16'h00C3);
        op(2, 16'h0000);
        chk(code_bank_select_out, 24'hC3);
        f(16'hFFFF, 24'h61FFFF);
        // The far-side memory answers one edge after the address stands.
        @(posedge clk_sys_in);
        #1;
        chk(mem_data, 24'h3C);
        f(16'h0000, 24'h000000);
        chk(code_bank_select_out, 24'hC3);
        op(4, 16'h0000);
        chk({push_valid_out, push_bank_out}, 24'h1C3);
        op(0, 16'h00FF);
        op(2, 16'h0000);
        f(16'h8001, 24'h7F8001);
        op(5, 16'h0022);
        chk({code_bank_select_out, next_bank_latch_out}, 24'h2222);
        op(6, 16'hFFFF);
        chk({pc_copy_valid_out, pair_index_word_out}, 24'h10001);
        rst(2'h2, 1'b0, 8'h3C);
        op(1, 16'h0011);
        op(2, 16'h0000);
        chk(code_bank_select_out, 24'h3C);
        f(16'h8010, 24'h1E0010);
        for (int c = 0; c < 2; c++) begin
            rst(c[1:0], 1'b1, 8'h55);
            op(0, 16'h0044);
            op(2, 16'h0000);
            chk(code_bank_select_out, 24'h01);
            f(16'h9234, 24'h009234);
            f(16'hFFFF, 24'h00FFFF);
        end
        print_verdict();
    end
endmodule
